// [ssr_pkg.sv]
// constants and types for the synchronous serial port block
// What this block does
// - receive starts only on single/continuous enable
// - data sampled on shift clock falling edge
// - single receive takes one word, then stops
// - continuous receive runs until enable cleared or an overrun error sets
// - both enables set behaves as continuous
// - word done sets flag; interrupt if enabled
// - ninth bit, errors in status; byte in data
// - clearing continuous enable clears receive errors
// - clock source clear means external shift clock
// - slave shifts while core sleeps
// - second word waits; empty flag stays clear
// - empty flag sets when second word moves
// - enabled empty flag wakes chip
// - slave ignores single receive enable
// - slave word before sleep loads data, wakes
// - master drives clock, idle level by polarity
// - empty flag cleared only by data write
package ssr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] A_INTCTL = 8'h00;
  localparam logic [7:0] A_IRQFLG = 8'h04;
  localparam logic [7:0] A_IRQEN = 8'h08;
  localparam logic [7:0] A_IRQPRI = 8'h0C;
  localparam logic [7:0] A_RXSC = 8'h10;
  localparam logic [7:0] A_RXDAT = 8'h14;
  localparam logic [7:0] A_TXSC = 8'h18;
  localparam logic [7:0] A_BAUDC = 8'h1C;
  localparam logic [7:0] A_BRGHI = 8'h20;
  localparam logic [7:0] A_BRGLO = 8'h24;
  localparam logic [7:0] A_TXDAT = 8'h28;
  // field positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int B_RCF = 5;
  localparam int B_TXF = 4;
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9 = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_ADDEN = 3;
  localparam int B_OVERRUN_ERROR_FLAG = 1;
  localparam int B_RECEIVE_NINTH_BIT = 0;
  localparam int B_CLOCK_SOURCE_SELECT = 7;
  localparam int B_TX9 = 6;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_TRMT = 1;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  localparam int B_CLOCK_POLARITY_SELECT = 4;
  localparam int B_BAUD_DIVIDER_16BIT_SELECT = 3;
  // reset value and word lengths
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] WORD8 = 4'h8;
  localparam logic [3:0] WORD9 = 4'h9;
  // link engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b100
  } ssr_state_type;
endpackage : ssr_pkg

// [ssr_sync_serial.sv]
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
// synchronous serial port: master/slave receive, slave transmit, wishbone
module ssr_sync_serial (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ssr_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ssr_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ssr_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic shiftClkIn,
  output logic shiftClkOut,
  output logic shiftClkOe,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic wakeReq,
  output logic irqOut
);
  import ssr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // bus side
  logic ackR; // answer, one cycle after request
  logic [31:0] datR; // read data captured with ack
  logic busHit; // request not yet answered
  logic wrNow; // write lands on the acked edge
  logic rdNow; // read side effects on the acked edge
  logic [31:0] rdMux; // read value before capture

  // software visible state
  logic [7:0] intctlR;
  logic [7:0] irqEnR;
  logic [7:0] irqPriR;
  logic [7:0] brgHiR;
  logic [7:0] brgLoR;
  logic spenR, rx9R, srenR, crenR, addenR, oerrR;
  logic rx9dR;
  logic csrcR, tx9R, txenR, syncR, tx9dR;
  logic sckpR, brg16R;
  logic [7:0] rxDataR; // receive data register
  logic rcFlagR; // receive complete flag
  logic [8:0] txHoldR; // transmit data register plus ninth bit
  logic txFullR; // holding register occupied
  logic txFlag; // transmit buffer empty flag

  // link side
  ssr_state_type stateR, stateNxt;
  logic [1:0] ckSyncR; // shift clock pin synchroniser
  logic [1:0] dtSyncR; // data pin synchroniser
  logic ckPrevR; // previous synchronised clock level
  logic slvFall; // falling edge of partner clock
  logic [15:0] brgCntR; // baud down-counter
  logic [15:0] brgDiv;
  logic brgTick; // half-period enable pulse
  logic mckR; // master shift clock level
  logic [3:0] bitCntR;
  logic [3:0] rxBits;
  logic [3:0] txBits;
  logic [8:0] rxShiftR; // receive shift register
  logic [8:0] txShiftR; // transmit shift register
  logic [8:0] rxWord; // aligned received word
  logic portOn, master;
  logic rxAllowed, txGo, sampleNow, rxDone, txDone, txLoad;

  // write/read decode; ack is registered so every access is 2 cycles
  assign busHit = wb_cyc_i && wb_stb_i && !ackR;
  assign wrNow = wb_cyc_i && wb_stb_i && ackR && wb_we_i && wb_sel_i[0];
  assign rdNow = wb_cyc_i && wb_stb_i && ackR && !wb_we_i;
  assign wb_ack_o = ackR;
  assign wb_dat_o = datR;

  // ack pulse and read data capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackR <= 1'b0;
      datR <= 32'h0000_0000;
    end else begin
      ackR <= busHit;
      if (busHit) begin
        datR <= rdMux;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (wb_adr_i)
      A_INTCTL: rdMux[7:0] = intctlR;
      A_IRQFLG: begin
        rdMux[B_RCF] = rcFlagR;
        rdMux[B_TXF] = txFlag;
      end
      A_IRQEN: rdMux[7:0] = irqEnR;
      A_IRQPRI: rdMux[7:0] = irqPriR;
      // ninth bit and errors live here; framing never fails in sync mode
      A_RXSC: rdMux[7:0] = {spenR, rx9R, srenR, crenR, addenR,
        1'b0, oerrR, rx9dR};
      A_RXDAT: rdMux[7:0] = rxDataR;
      A_TXSC: rdMux[7:0] = {csrcR, tx9R, txenR, syncR, 2'b00,
        (stateR != ST_TX), tx9dR};
      A_BAUDC: begin
        rdMux[B_CLOCK_POLARITY_SELECT] = sckpR;
        rdMux[B_BAUD_DIVIDER_16BIT_SELECT] = brg16R;
      end
      A_BRGHI: rdMux[7:0] = brgHiR;
      A_BRGLO: rdMux[7:0] = brgLoR;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // plain control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intctlR <= RST_BYTE;
      irqEnR <= RST_BYTE;
      irqPriR <= RST_BYTE;
      brgHiR <= RST_BYTE;
      brgLoR <= RST_BYTE;
      {spenR, rx9R, addenR} <= 3'b000;
      {csrcR, tx9R, txenR, syncR, tx9dR} <= 5'b00000;
      {sckpR, brg16R} <= 2'b00;
    end else if (wrNow) begin
      case (wb_adr_i)
        A_INTCTL: intctlR <= wb_dat_i[7:0];
        A_IRQEN: irqEnR <= wb_dat_i[7:0];
        A_IRQPRI: irqPriR <= wb_dat_i[7:0];
        A_BRGHI: brgHiR <= wb_dat_i[7:0];
        A_BRGLO: brgLoR <= wb_dat_i[7:0];
        A_RXSC: begin
          spenR <= wb_dat_i[B_SERIAL_PORT_ENABLE];
          rx9R <= wb_dat_i[B_RX9];
          addenR <= wb_dat_i[B_ADDEN];
        end
        A_TXSC: begin
          csrcR <= wb_dat_i[B_CLOCK_SOURCE_SELECT];
          tx9R <= wb_dat_i[B_TX9];
          txenR <= wb_dat_i[B_TRANSMIT_ENABLE];
          syncR <= wb_dat_i[B_SYNC];
          tx9dR <= wb_dat_i[B_TRANSMIT_NINTH_BIT];
        end
        A_BAUDC: begin
          sckpR <= wb_dat_i[B_CLOCK_POLARITY_SELECT];
          brg16R <= wb_dat_i[B_BAUD_DIVIDER_16BIT_SELECT];
        end
        default: ;
      endcase
    end
  end

  // mode decode
  assign portOn = spenR && syncR;
  assign master = csrcR;
  // slave looks only at the continuous enable; it wins when both set
  assign rxAllowed = portOn && !oerrR &&
    (master ? (srenR || crenR) : crenR);
  // continuous receive enable overrides transmit; master transmit not built
  assign txGo = portOn && !master && txenR && !rxAllowed;
  assign rxBits = rx9R ? WORD9 : WORD8;
  assign txBits = tx9R ? WORD9 : WORD8;
  assign rxWord = rx9R ? rxShiftR : {1'b0, rxShiftR[8:1]};

  // receive enables: single clears after its word, continuous stays
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      srenR <= 1'b0;
      crenR <= 1'b0;
    end else if (wrNow && wb_adr_i == A_RXSC) begin
      srenR <= wb_dat_i[B_SINGLE_RECEIVE_ENABLE];
      crenR <= wb_dat_i[B_CONTINUOUS_RECEIVE_ENABLE]; // only software clears it
    end else if (rxDone && master) begin
      srenR <= 1'b0;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ckSyncR <= 2'b00;
      dtSyncR <= 2'b00;
      ckPrevR <= 1'b0;
    end else begin
      ckSyncR <= {ckSyncR[0], shiftClkIn};
      dtSyncR <= {dtSyncR[0], serialDataIn};
      ckPrevR <= ckSyncR[1];
    end
  end
  // partner clock edge, works without our core clock gating
  assign slvFall = ckPrevR && !ckSyncR[1];

  // baud generator: one tick per half shift clock period
  assign brgDiv = brg16R ? {brgHiR, brgLoR} : {8'h00, brgLoR};
  assign brgTick = (stateR == ST_RX) && master && (brgCntR == 16'h0000);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      brgCntR <= 16'h0000;
    end else if (stateR != ST_RX || brgTick) begin
      brgCntR <= brgDiv; // restart keeps first half period full
    end else begin
      brgCntR <= brgCntR - 16'h0001;
    end
  end

  // master clock level; rests at the polarity level outside words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mckR <= 1'b0;
    end else if (stateR != ST_RX || !master) begin
      mckR <= sckpR;
    end else if (brgTick && !(bitCntR == rxBits)) begin
      mckR <= !mckR;
    end else if (brgTick && mckR != sckpR) begin
      mckR <= !mckR; // return to idle after last bit
    end
  end
  assign shiftClkOut = mckR;
  assign shiftClkOe = portOn && master;

  // sample strobes: always on a falling edge of the shift clock
  assign sampleNow = (stateR == ST_RX) && !(bitCntR == rxBits) &&
    (master ? (brgTick && mckR) : slvFall);
  // master word ends once the clock is back at rest
  assign rxDone = (stateR == ST_RX) && (bitCntR == rxBits) &&
    (!master || mckR == sckpR);
  assign txDone = (stateR == ST_TX) && (bitCntR == txBits);
  assign txLoad = (stateR == ST_IDLE) && txGo && txFullR;

  // link engine next state
  always_comb begin
    stateNxt = stateR;
    case (stateR)
      ST_IDLE: begin
        if (rxAllowed) begin
          stateNxt = ST_RX;
        end else if (txLoad) begin
          stateNxt = ST_TX;
        end
      end
      ST_RX: begin
        if (!rxAllowed || rxDone) begin
          stateNxt = ST_IDLE; // continuous restarts next cycle
        end
      end
      ST_TX: begin
        if (txDone) begin
          stateNxt = ST_IDLE;
        end
      end
      default: stateNxt = ST_IDLE;
    endcase
  end

  // state register; port disable holds the engine idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateR <= ST_IDLE;
    end else if (!spenR) begin
      stateR <= ST_IDLE;
    end else begin
      stateR <= stateNxt;
    end
  end

  // bit counter shared by both directions
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bitCntR <= 4'h0;
    end else if (stateR != stateNxt || !spenR) begin
      bitCntR <= 4'h0;
    end else if (sampleNow || (stateR == ST_TX && slvFall)) begin
      bitCntR <= bitCntR + 4'h1;
    end
  end

  // receive shift register, lsb first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxShiftR <= 9'h000;
    end else if (sampleNow) begin
      rxShiftR <= {dtSyncR[1], rxShiftR[8:1]};
    end
  end

  // receive data, ninth bit, flag and overrun
  // a finished word wins over a same-cycle read that clears the flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxDataR <= 8'h00;
      rx9dR <= 1'b0;
      rcFlagR <= 1'b0;
      oerrR <= 1'b0;
    end else if (!spenR) begin
      rcFlagR <= 1'b0;
      oerrR <= 1'b0;
    end else begin
      if (rdNow && wb_adr_i == A_RXDAT) begin
        rcFlagR <= 1'b0;
      end
      if (wrNow && wb_adr_i == A_RXSC && !wb_dat_i[B_CONTINUOUS_RECEIVE_ENABLE]) begin
        oerrR <= 1'b0;
      end
      if (rxDone && rcFlagR && !(rdNow && wb_adr_i == A_RXDAT)) begin
        oerrR <= 1'b1; // unread word kept, new one dropped
      end else if (rxDone) begin
        rxDataR <= rxWord[7:0];
        rx9dR <= rxWord[8];
        rcFlagR <= 1'b1;
      end
    end
  end

  // transmit holding register; only a data write empties the flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txHoldR <= 9'h000;
      txFullR <= 1'b0;
    end else if (!spenR) begin
      txFullR <= 1'b0;
    end else if (wrNow && wb_adr_i == A_TXDAT) begin
      txHoldR <= {tx9dR, wb_dat_i[7:0]};
      txFullR <= 1'b1;
    end else if (txLoad) begin
      txFullR <= 1'b0;
    end
  end
  // second word waiting keeps this low while the first shifts
  assign txFlag = !txFullR;

  // transmit shift register, next bit after each partner falling edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txShiftR <= 9'h000;
    end else if (txLoad) begin
      txShiftR <= txHoldR;
    end else if (stateR == ST_TX && slvFall) begin
      txShiftR <= {1'b0, txShiftR[8:1]};
    end
  end
  assign serialDataOut = txShiftR[0];
  assign serialDataOe = (stateR == ST_TX);

  // wake works without global enables; vectoring needs both
  assign wakeReq = (rcFlagR && irqEnR[B_RCF]) ||
    (txFlag && irqEnR[B_TXF]);
  assign irqOut = wakeReq && intctlR[B_GIE] && intctlR[B_PERIPHERAL_INTERRUPT_ENABLE];

  // checks; clock and reset come from the defaults at the top
  sequence s_load;
    txLoad;
  endsequence
  sequence s_shifting;
    (stateR == ST_TX) && !txFlag;
  endsequence
  a_rx_start_gate: assert property
    ((stateR == ST_IDLE && stateNxt == ST_RX) |-> rxAllowed)
    else $error("receive began without an enable");
  a_sample_on_fall: assert property
    ((stateR == ST_RX && $past(stateR) == ST_RX &&
      rxShiftR != $past(rxShiftR)) |->
     ($past(master) ? ($past(mckR) && !mckR) :
      ($past(ckPrevR) && !$past(ckSyncR[1]))))
    else $error("data sampled off a falling edge");
  a_single_stops: assert property
    ((rxDone && master && !(wrNow && wb_adr_i == A_RXSC)) |=> !srenR)
    else $error("single receive left enabled");
  a_cont_persists: assert property
    ((rxDone && crenR && !(wrNow && wb_adr_i == A_RXSC)) |=> crenR)
    else $error("continuous enable dropped by hardware");
  a_rc_flag_set: assert property
    ((rxDone && !rcFlagR && spenR) |=>
     rcFlagR && rxDataR == $past(rxWord[7:0]))
    else $error("completed word not flagged");
  a_err_clear: assert property
    ((wrNow && wb_adr_i == A_RXSC && !wb_dat_i[B_CONTINUOUS_RECEIVE_ENABLE] && !rxDone) |=>
     !oerrR)
    else $error("overrun survived enable clear");
  a_slave_no_clk: assert property
    (!csrcR |-> !shiftClkOe)
    else $error("slave drove the shift clock");
  a_tx_second_wait: assert property
    (s_load ##[1:8] (wrNow && wb_adr_i == A_TXDAT) |=> s_shifting)
    else $error("empty flag set while word waits");
  a_idle_level: assert property
    ((master && stateR == ST_IDLE && $past(stateR) == ST_IDLE) |->
     shiftClkOut == $past(sckpR))
    else $error("master clock not at rest level");
  a_wake_tx: assert property
    ((txLoad && irqEnR[B_TXF] && !(wrNow && wb_adr_i == A_TXDAT)) |=>
     wakeReq)
    else $error("empty flag did not wake");
  a_slave_no_single_receive_enable: assert property
    ((portOn && !master && !crenR && stateR == ST_IDLE) |=>
     stateR != ST_RX)
    else $error("slave received on single enable");

endmodule : ssr_sync_serial

// [ssr_partner.sv]
`timescale 1ns/100ps
// far-side synchronous serial partner: answers a master, clocks a slave
module ssr_partner (
  input wire logic clk,
  input wire logic clkWire,
  input wire logic dataWire,
  output logic ptClk,
  output logic ptData
);
  logic [8:0] word_r; // word offered to a clocking master
  int nBits; // length of that word
  int idx; // next bit to present
  logic lastClk; // wire clock one cycle back
  logic ansOn; // answering a master clock
  logic busy_r; // clocking a frame of our own
  initial begin
    ptClk = 1'b0;
    ptData = 1'b0;
    word_r = 9'h000;
    nBits = 8;
    idx = 0;
    lastClk = 1'b0;
    ansOn = 1'b0;
    busy_r = 1'b0;
  end
  // new bit just after each rise, held across the fall
  always @(posedge clk) begin
    lastClk <= clkWire;
    if (ansOn && clkWire && !lastClk) begin
      ptData <= word_r[idx];
      idx <= (idx + 1) % nBits;
    end else if (!ansOn && !busy_r) begin
      // released line: no stale level the device could lean on
      ptData <= ~ptData;
    end
  end
  // arm the answer for a master, lsb first
  task automatic load(input logic [8:0] w, input int n);
    word_r = w;
    nBits = n;
    idx = 0;
    ansOn = 1'b1;
  endtask : load
  // one frame at 800 ns per bit; clock rests low outside it
  task automatic frame(input logic [8:0] w, input int n,
                       output logic [8:0] got);
    ansOn = 1'b0;
    busy_r = 1'b1;
    got = 9'h000;
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge clk);
      ptData <= w[i];
      repeat (2) @(posedge clk);
      // take the device bit at our rising edge
      got[i] = dataWire;
      ptClk <= 1'b1;
      repeat (3) @(posedge clk);
      ptClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    busy_r = 1'b0;
  endtask : frame
endmodule : ssr_partner

// [ssr_sync_serial_test.sv]
`timescale 1ns/100ps
// self-checking bench for the synchronous serial port block
module ssr_sync_serial_test;
  import ssr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, sckOut, sckOe, sdOut, sdOe, wake, irq;
  logic ptClk, ptData, clkWire, dataWire;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int falls = 0; // falling edges of the master clock
  logic lastSck = 1'b0;
  logic [7:0] q; // last read byte
  logic [8:0] got; // last word taken by the partner
  always #50 clk = ~clk;
  // wire levels from both drivers' enables
  assign clkWire = sckOe ? sckOut : ptClk;
  assign dataWire = sdOe ? sdOut : ptData;
  ssr_sync_serial i_ssr_sync_serial (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .shiftClkIn(clkWire), .shiftClkOut(sckOut), .shiftClkOe(sckOe),
    .serialDataIn(dataWire), .serialDataOut(sdOut),
    .serialDataOe(sdOe), .wakeReq(wake), .irqOut(irq));
  ssr_partner i_ssr_partner (.clk(clk), .clkWire(clkWire),
    .dataWire(dataWire), .ptClk(ptClk), .ptData(ptData));
  // fall counter and hang guard
  always @(posedge clk) begin
    lastSck <= sckOut;
    if (lastSck && !sckOut) begin
      falls <= falls + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    // no local limit: only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    chk({1'b0, rdat[15:8]}, 9'h000);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk({1'b0, q}, {1'b0, exp});
  endtask : rdChk
  // bounded wait on the wake line
  task automatic waitWake;
    int n;
    n = 0;
    // step an edge first so a flag cleared by the last read is seen
    do begin
      @(posedge clk);
      n++;
    end while (wake !== 1'b1 && n < 400);
    chk(9'(wake), 9'h001);
  endtask : waitWake
  task automatic t_reset;
    rdChk(A_RXSC, 8'h00);
    rdChk(A_IRQFLG, 8'h10);
    rdChk(8'h30, 8'h00);
  endtask : t_reset
  // master single word, half period of four clocks
  task automatic t_master_single;
    bus(1'b1, A_BRGLO, 8'h03);
    bus(1'b1, A_BAUDC, 8'h10);
    bus(1'b1, A_TXSC, 8'h90);
    bus(1'b1, A_RXSC, 8'h80);
    repeat (3) @(posedge clk);
    chk(9'(sckOut), 9'h001);
    chk(9'(sckOe), 9'h001);
    bus(1'b1, A_BAUDC, 8'h00);
    bus(1'b1, A_IRQEN, 8'h20);
    bus(1'b1, A_INTCTL, 8'hC0);
    i_ssr_partner.load(9'h0A5, 8);
    falls = 0;
    repeat (20) @(posedge clk);
    chk(9'(falls), 9'h000);
    bus(1'b1, A_RXSC, 8'hA0);
    waitWake();
    chk(9'(irq), 9'h001);
    chk(9'(falls), 9'h008);
    rdChk(A_RXDAT, 8'hA5);
    rdChk(A_RXSC, 8'h80);
    chk(9'(wake), 9'h000);
    repeat (60) @(posedge clk);
    chk(9'(falls), 9'h008);
  endtask : t_master_single
  // both enables, nine bits, overrun then cleared
  task automatic t_master_cont;
    // sixteen-bit divider with a zero high byte keeps the same rate
    bus(1'b1, A_BAUDC, 8'h08);
    i_ssr_partner.load(9'h13C, 9);
    bus(1'b1, A_RXSC, 8'hF0);
    waitWake();
    bus(1'b0, A_RXSC, 8'h00);
    chk({1'b0, q & 8'hDF}, 9'h0D1);
    rdChk(A_RXDAT, 8'h3C);
    waitWake();
    repeat (120) @(posedge clk);
    bus(1'b0, A_RXSC, 8'h00);
    chk(9'(q[B_OVERRUN_ERROR_FLAG]), 9'h001);
    bus(1'b1, A_RXSC, 8'hC0);
    bus(1'b0, A_RXSC, 8'h00);
    chk(9'(q[B_OVERRUN_ERROR_FLAG]), 9'h000);
    falls = 0;
    repeat (100) @(posedge clk);
    chk(9'(falls), 9'h000);
  endtask : t_master_cont
  // slave transmit: two words queued, partner clocks them out
  task automatic t_slave_tx;
    bus(1'b1, A_RXSC, 8'h00);
    bus(1'b1, A_INTCTL, 8'h00);
    bus(1'b1, A_IRQEN, 8'h10);
    bus(1'b1, A_TXSC, 8'h71);
    bus(1'b1, A_RXSC, 8'h80);
    bus(1'b1, A_TXDAT, 8'h5A);
    bus(1'b1, A_TXDAT, 8'hC3);
    bus(1'b1, A_IRQFLG, 8'hFF);
    rdChk(A_IRQFLG, 8'h00);
    chk(9'(wake), 9'h000);
    chk(9'(sckOe), 9'h000);
    i_ssr_partner.frame(9'h000, 9, got);
    chk(got, 9'h15A);
    repeat (6) @(posedge clk);
    chk(9'(wake), 9'h001);
    chk(9'(irq), 9'h000);
    i_ssr_partner.frame(9'h000, 9, got);
    chk(got, 9'h1C3);
    repeat (2) @(posedge clk);
    chk(9'(sdOe), 9'h000);
  endtask : t_slave_tx
  // slave receive: single enable ignored, continuous one wakes
  task automatic t_slave_rx;
    bus(1'b1, A_RXSC, 8'h00);
    bus(1'b1, A_TXSC, 8'h10);
    bus(1'b1, A_IRQEN, 8'h20);
    bus(1'b1, A_RXSC, 8'hA0);
    i_ssr_partner.frame(9'h096, 8, got);
    repeat (6) @(posedge clk);
    chk(9'(wake), 9'h000);
    bus(1'b1, A_RXSC, 8'h90);
    i_ssr_partner.frame(9'h069, 8, got);
    repeat (6) @(posedge clk);
    chk(9'(wake), 9'h001);
    rdChk(A_RXDAT, 8'h69);
  endtask : t_slave_rx
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_master_single();
    t_master_cont();
    t_slave_tx();
    t_slave_rx();
    final_report();
  end
endmodule : ssr_sync_serial_test
